/* File: src/spa_arbiter.sv */
// Arbiter between software and slave port accesses with fairness counter
`timescale 1ns/1ps
//
// Contract
// [RL1] Fairness reload value held in control bits 15:11, reset value one.
// [RL2] Software sets reload one and control zero or one for round-robin.
// [RL3] Software never programs reload zero; demoted side would always win.
// [RL4] Reload value unused while control field selects external priority.
// [RL5] Threshold in bits 10:2; top bit clear gives eight-bit priority.
// [RL6] Threshold all ones means minus one, ending in zero minus two.
// [RL7] Control zero demotes slave port accesses against software accesses.
// [RL8] Control one demotes software accesses against slave port accesses.
// [RL9] Control two loads reload at or above threshold, else one.
// [RL10] Larger decoded priority value means lower priority in comparisons.
// [RL11] Control three lets the external priority input pick the winner.
// [RL12] Favoured wins decrement counter; at zero demoted wins once, reload.
module spa_arbiter #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [ADDR_W-1:0]          wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [spa_pkg::DATA_W-1:0] wb_dat_i,
  output logic      [spa_pkg::DATA_W-1:0] wb_dat_o,
  output logic                            wb_ack_o,
  input  wire logic                       sw_req_i,
  input  wire logic                       slv_req_i,
  input  wire logic [spa_pkg::THR_W-1:0]  exec_pri_i,
  input  wire logic                       ext_pri_i,
  output logic                            sw_gnt_o,
  output logic                            slv_gnt_o
);
  if (ADDR_W < 3 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must lie between 3 and 32");
  end

  typedef struct packed {
    logic                      sw_gnt;
    logic                      slv_gnt;
    logic [spa_pkg::CNT_W-1:0] cnt;
  } spa_core_s;

  localparam spa_core_s RST_STATE = '{sw_gnt: 1'b0, slv_gnt: 1'b0,
                                      cnt: spa_pkg::RELOAD_RST};

  spa_cfg_if cfg ();

  spa_wb_regs #(
    .ADDR_W (ADDR_W)
  ) u_regs (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .cfg      (cfg.regs)
  );

  spa_core_s                 s_reg;
  spa_core_s                 s_next;
  spa_pkg::spa_ctl_e         ctl;
  spa_pkg::spa_pri_t         thr_v;
  spa_pkg::spa_pri_t         exe_v;
  logic                      at_or_above;
  logic                      contention;
  logic                      slv_favoured;
  logic [spa_pkg::CNT_W-1:0] reload_v;

  always_comb begin
    ctl         = spa_pkg::spa_ctl_e'(cfg.ctl);
    thr_v       = spa_pkg::decode_pri(cfg.thr); // [RL5] [RL6]
    exe_v       = spa_pkg::decode_pri(exec_pri_i);
    at_or_above = (exe_v <= thr_v); // [RL10]
    contention  = sw_req_i & slv_req_i;
    // Below the threshold the counter falls back to one, so the sides alternate
    if (ctl == spa_pkg::SPA_CTL_THRESHOLD && !at_or_above) begin
      reload_v = spa_pkg::RR_RELOAD; // [RL9]
    end else begin
      reload_v = cfg.reload; // [RL9]
    end
    case (ctl)
      spa_pkg::SPA_CTL_DEMOTE_SLV: slv_favoured = 1'b0; // [RL7]
      spa_pkg::SPA_CTL_DEMOTE_SW:  slv_favoured = 1'b1; // [RL8]
      spa_pkg::SPA_CTL_THRESHOLD:  slv_favoured = 1'b0; // [RL9]
      spa_pkg::SPA_CTL_EXTERNAL:   slv_favoured = ext_pri_i; // [RL11]
      default:                     slv_favoured = 1'b0;
    endcase
    s_next         = s_reg;
    s_next.sw_gnt  = sw_req_i;
    s_next.slv_gnt = slv_req_i;
    if (contention) begin
      if (ctl == spa_pkg::SPA_CTL_EXTERNAL) begin
        // Counter frozen: the integrator's input alone decides here
        s_next.slv_gnt = slv_favoured; // [RL4] [RL11]
        s_next.sw_gnt  = ~slv_favoured;
      end else if (s_reg.cnt == spa_pkg::CNT_ZERO) begin
        s_next.slv_gnt = ~slv_favoured; // [RL12]
        s_next.sw_gnt  = slv_favoured;
        s_next.cnt     = reload_v; // [RL1] [RL12]
      end else begin
        s_next.slv_gnt = slv_favoured; // [RL12]
        s_next.sw_gnt  = ~slv_favoured;
        s_next.cnt     = s_reg.cnt - spa_pkg::CNT_ONE; // [RL12]
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= RST_STATE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sw_gnt_o    = s_reg.sw_gnt;
  assign slv_gnt_o   = s_reg.slv_gnt;
  assign cfg.cnt     = s_reg.cnt;
  assign cfg.sw_gnt  = s_reg.sw_gnt;
  assign cfg.slv_gnt = s_reg.slv_gnt;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_EXT_FROZEN: assert property ((contention && ctl == spa_pkg::SPA_CTL_EXTERNAL) // [RL4]
    |=> s_reg.cnt == $past(s_reg.cnt))
    else $error("Counter moved under external priority");
  AST_EXT_WINNER: assert property ((contention && ctl == spa_pkg::SPA_CTL_EXTERNAL) // [RL11]
    |=> (slv_gnt_o == $past(ext_pri_i) && sw_gnt_o == !$past(ext_pri_i)))
    else $error("External priority input not followed");
  AST_DEMOTE_SLV: assert property ((contention && ctl == spa_pkg::SPA_CTL_DEMOTE_SLV // [RL7]
    && s_reg.cnt != spa_pkg::CNT_ZERO) |=> (sw_gnt_o && !slv_gnt_o))
    else $error("Slave port not demoted");
  AST_DEMOTE_SW: assert property ((contention && ctl == spa_pkg::SPA_CTL_DEMOTE_SW // [RL8]
    && s_reg.cnt != spa_pkg::CNT_ZERO) |=> (slv_gnt_o && !sw_gnt_o))
    else $error("Software not demoted");
  AST_THR_RR: assert property ((contention && ctl == spa_pkg::SPA_CTL_THRESHOLD // [RL9]
    && s_reg.cnt == spa_pkg::CNT_ZERO && exe_v > thr_v) |=> s_reg.cnt == spa_pkg::RR_RELOAD)
    else $error("Counter not loaded with one below threshold");
  AST_THR_LOAD: assert property ((contention && ctl == spa_pkg::SPA_CTL_THRESHOLD // [RL10]
    && s_reg.cnt == spa_pkg::CNT_ZERO && exe_v <= thr_v) |=> s_reg.cnt == $past(cfg.reload))
    else $error("Counter not loaded with reload at threshold");
  AST_TURN: assert property ((contention && ctl == spa_pkg::SPA_CTL_DEMOTE_SLV // [RL12]
    && s_reg.cnt == spa_pkg::CNT_ZERO) |=> (slv_gnt_o && !sw_gnt_o))
    else $error("Demoted side not granted at zero count");
  AST_DECREMENT: assert property ((contention && ctl != spa_pkg::SPA_CTL_EXTERNAL // [RL12]
    && s_reg.cnt != spa_pkg::CNT_ZERO) |=> s_reg.cnt == $past(s_reg.cnt) - 5'h01)
    else $error("Counter did not decrement on favoured win");
  AST_PRI_HF: assert property ((cfg.thr == spa_pkg::PRI_HARD_FAULT) // [RL6]
    |-> thr_v == spa_pkg::PRI_VAL_HARD_FAULT)
    else $error("Hard fault threshold decoded wrongly");
  AST_PRI_LOW: assert property (!cfg.thr[8] |-> thr_v == $signed({2'b00, cfg.thr[7:0]})) // [RL5]
    else $error("Plain threshold decoded wrongly");
  AST_ONE_GRANT: assert property (!(sw_gnt_o && slv_gnt_o))
    else $error("Both sides granted at once");
  AST_IDLE_GNT: assert property (!contention |=> (sw_gnt_o == $past(sw_req_i)
    && slv_gnt_o == $past(slv_req_i)))
    else $error("Grant differs from request without contention");
  AST_IDLE_CNT: assert property (!contention |=> s_reg.cnt == $past(s_reg.cnt)) // [RL12]
    else $error("Counter moved without contention");
  AST_DEMOTE_THR: assert property ((contention && ctl == spa_pkg::SPA_CTL_THRESHOLD // [RL9]
    && s_reg.cnt != spa_pkg::CNT_ZERO) |=> (sw_gnt_o && !slv_gnt_o))
    else $error("Slave port not demoted in threshold mode");
  AST_TURN_SW: assert property ((contention && ctl == spa_pkg::SPA_CTL_DEMOTE_SW // [RL12]
    && s_reg.cnt == spa_pkg::CNT_ZERO) |=> (sw_gnt_o && !slv_gnt_o))
    else $error("Software not granted at zero count");
  AST_TURN_THR: assert property ((contention && ctl == spa_pkg::SPA_CTL_THRESHOLD // [RL9]
    && s_reg.cnt == spa_pkg::CNT_ZERO) |=> (slv_gnt_o && !sw_gnt_o))
    else $error("Slave port not granted at zero count");
  AST_FIXED_LOAD: assert property ((contention && s_reg.cnt == spa_pkg::CNT_ZERO // [RL1]
    && (ctl == spa_pkg::SPA_CTL_DEMOTE_SLV || ctl == spa_pkg::SPA_CTL_DEMOTE_SW))
    |=> s_reg.cnt == $past(cfg.reload))
    else $error("Counter not loaded with reload value");
  AST_PRI_NMI: assert property ((cfg.thr == spa_pkg::PRI_NMI) // [RL6]
    |-> thr_v == spa_pkg::PRI_VAL_NMI)
    else $error("Non-maskable threshold decoded wrongly");
  AST_SW_NEEDS_REQ: assert property (!sw_req_i |=> !sw_gnt_o)
    else $error("Software granted without request");
  AST_SLV_NEEDS_REQ: assert property (!slv_req_i |=> !slv_gnt_o)
    else $error("Slave port granted without request");

  COV_RR: cover property ((contention && ctl == spa_pkg::SPA_CTL_DEMOTE_SLV) [*4]);
  COV_THR: cover property (contention && ctl == spa_pkg::SPA_CTL_THRESHOLD && !at_or_above);
  COV_EXT: cover property (contention && ctl == spa_pkg::SPA_CTL_EXTERNAL && ext_pri_i);
  COV_TURN_SW: cover property (contention && ctl == spa_pkg::SPA_CTL_DEMOTE_SW
    && s_reg.cnt == spa_pkg::CNT_ZERO);
  COV_THR_LOAD: cover property (contention && ctl == spa_pkg::SPA_CTL_THRESHOLD && at_or_above
    && s_reg.cnt == spa_pkg::CNT_ZERO);
endmodule

/* File: src/spa_cfg_if.sv */
// Configuration and status carrier between register slave and arbiter core
`timescale 1ns/1ps
interface spa_cfg_if;
  logic [spa_pkg::CTL_W-1:0] ctl;
  logic [spa_pkg::CNT_W-1:0] reload;
  logic [spa_pkg::THR_W-1:0] thr;
  logic [spa_pkg::CNT_W-1:0] cnt;
  logic                      sw_gnt;
  logic                      slv_gnt;
  modport regs (output ctl, output reload, output thr,
                input cnt, input sw_gnt, input slv_gnt);
  modport core (input ctl, input reload, input thr,
                output cnt, output sw_gnt, output slv_gnt);
endinterface

/* File: src/spa_pkg.sv */
// Shared constants, types and helpers of the slave port priority arbiter
package spa_pkg;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned CNT_W       = 5;
  localparam int unsigned THR_W       = 9;
  localparam int unsigned CTL_W       = 2;
  // Register byte offsets
  localparam logic [7:0]  CTRL_OFS    = 8'h00;
  localparam logic [7:0]  STAT_OFS    = 8'h04;
  // Control register fields
  localparam int unsigned RELOAD_LSB  = 11;
  localparam int unsigned THR_LSB     = 2;
  localparam int unsigned CTL_LSB     = 0;
  // Status register fields
  localparam int unsigned CNT_LSB     = 0;
  localparam int unsigned SW_GNT_BIT  = 8;
  localparam int unsigned SLV_GNT_BIT = 9;
  // Reset values and counter constants
  localparam logic [CNT_W-1:0] RELOAD_RST = 5'h01;
  localparam logic [THR_W-1:0] THR_RST    = 9'h000;
  localparam logic [CTL_W-1:0] CTL_RST    = 2'h0;
  localparam logic [CNT_W-1:0] RR_RELOAD  = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE    = 5'h01;
  // Priority encodings
  localparam logic [THR_W-1:0] PRI_HARD_FAULT = 9'h1FF;
  localparam logic [THR_W-1:0] PRI_NMI        = 9'h1FE;
  localparam int unsigned      PRI_TOP_BIT    = 8;
  typedef logic signed [9:0] spa_pri_t;
  localparam spa_pri_t PRI_VAL_HARD_FAULT = -10'sd1;
  localparam spa_pri_t PRI_VAL_NMI        = -10'sd2;

  typedef enum logic [CTL_W-1:0] {
    SPA_CTL_DEMOTE_SLV,
    SPA_CTL_DEMOTE_SW,
    SPA_CTL_THRESHOLD,
    SPA_CTL_EXTERNAL
  } spa_ctl_e;

  // Maps the 9-bit encoding to a signed value; larger means lower priority
  function automatic spa_pri_t decode_pri(input logic [THR_W-1:0] enc);
    spa_pri_t val;
    if (!enc[PRI_TOP_BIT]) begin
      val = spa_pri_t'({2'b00, enc[7:0]}); // [RL5]
    end else if (enc == PRI_NMI) begin
      val = PRI_VAL_NMI; // [RL6]
    end else begin
      // Undefined codes with the top bit set are taken as the hard fault level
      val = PRI_VAL_HARD_FAULT; // [RL6]
    end
    return val;
  endfunction
endpackage

/* File: src/spa_wb_regs.sv */
// Classic Wishbone slave holding the priority control and status registers
`timescale 1ns/1ps
module spa_wb_regs #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [ADDR_W-1:0]          wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [spa_pkg::DATA_W-1:0] wb_dat_i,
  output logic      [spa_pkg::DATA_W-1:0] wb_dat_o,
  output logic                            wb_ack_o,
  spa_cfg_if.regs                         cfg
);
  typedef struct packed {
    logic [spa_pkg::CTL_W-1:0]  ctl;
    logic [spa_pkg::CNT_W-1:0]  reload;
    logic [spa_pkg::THR_W-1:0]  thr;
    logic                       ack;
    logic [spa_pkg::DATA_W-1:0] dat;
  } spa_regs_s;

  localparam spa_regs_s RST_STATE = '{ctl: spa_pkg::CTL_RST, reload: spa_pkg::RELOAD_RST,
                                      thr: spa_pkg::THR_RST, ack: 1'b0, dat: '0};

  spa_regs_s                  s_reg;
  spa_regs_s                  s_next;
  logic [spa_pkg::DATA_W-1:0] ctrl_word;
  logic [spa_pkg::DATA_W-1:0] stat_word;
  logic [spa_pkg::DATA_W-1:0] wr_word;
  logic                       take;
  logic                       hit_ctrl;
  logic                       hit_stat;

  always_comb begin
    ctrl_word = '0;
    ctrl_word[spa_pkg::RELOAD_LSB +: spa_pkg::CNT_W] = s_reg.reload; // [RL1]
    ctrl_word[spa_pkg::THR_LSB +: spa_pkg::THR_W]    = s_reg.thr; // [RL5]
    ctrl_word[spa_pkg::CTL_LSB +: spa_pkg::CTL_W]    = s_reg.ctl;
    stat_word = '0;
    stat_word[spa_pkg::CNT_LSB +: spa_pkg::CNT_W] = cfg.cnt;
    stat_word[spa_pkg::SW_GNT_BIT]                = cfg.sw_gnt;
    stat_word[spa_pkg::SLV_GNT_BIT]               = cfg.slv_gnt;
    take     = wb_cyc_i & wb_stb_i & ~s_reg.ack;
    hit_ctrl = (wb_adr_i == ADDR_W'(spa_pkg::CTRL_OFS));
    hit_stat = (wb_adr_i == ADDR_W'(spa_pkg::STAT_OFS));
    // Only the two low byte lanes hold bits; upper lanes are ignored
    wr_word = ctrl_word;
    if (wb_sel_i[0]) begin
      wr_word[7:0] = wb_dat_i[7:0];
    end
    if (wb_sel_i[1]) begin
      wr_word[15:8] = wb_dat_i[15:8];
    end
    s_next     = s_reg;
    s_next.ack = take;
    s_next.dat = '0;
    if (take) begin
      if (wb_we_i && hit_ctrl) begin
        s_next.reload = wr_word[spa_pkg::RELOAD_LSB +: spa_pkg::CNT_W]; // [RL1]
        s_next.thr    = wr_word[spa_pkg::THR_LSB +: spa_pkg::THR_W]; // [RL5]
        s_next.ctl    = wr_word[spa_pkg::CTL_LSB +: spa_pkg::CTL_W];
      end else if (!wb_we_i && hit_ctrl) begin
        s_next.dat = ctrl_word;
      end else if (!wb_we_i && hit_stat) begin
        s_next.dat = stat_word;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= RST_STATE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_dat_o   = s_reg.dat;
  assign wb_ack_o   = s_reg.ack;
  assign cfg.ctl    = s_reg.ctl;
  assign cfg.reload = s_reg.reload;
  assign cfg.thr    = s_reg.thr;

  AST_RELOAD_RST: assert property (@(posedge clk_i) $past(rst_i) |-> // [RL1]
    (s_reg.reload == spa_pkg::RELOAD_RST && s_reg.ctl == spa_pkg::CTL_RST))
    else $error("Control register not at reset value after reset");
  AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("Ack held longer than one cycle");
endmodule

/* File: tb/spa_arbiter_tb.sv */
// Self-checking bench for the slave port priority arbiter
`timescale 1ns/1ps
module spa_arbiter_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        sw_req = 1'b0;
  logic        want = 1'b0;
  logic        hi = 1'b0;
  logic [8:0]  pri = 9'h000;
  logic        slv_req;
  logic        ext_pri;
  logic        sw_gnt_o;
  logic        slv_gnt_o;
  logic [1:0]  m_ctl = 2'h0;
  logic [4:0]  m_rld = 5'h01;
  logic [4:0]  m_cnt = 5'h01;
  logic [8:0]  m_thr = 9'h000;
  logic [31:0] q;
  int          mismatches = 0;
  int          compares = 0;

  spa_arbiter spa_arbiter_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sw_req_i(sw_req), .slv_req_i(slv_req), .exec_pri_i(pri),
    .ext_pri_i(ext_pri), .sw_gnt_o(sw_gnt_o), .slv_gnt_o(slv_gnt_o));
  spa_slv_model spa_slv_model_inst (.rst_i(rst_i), .want_i(want),
    .hi_pri_i(hi), .slv_req_o(slv_req), .ext_pri_o(ext_pri));

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  task automatic end_sim();
    $display("Compares %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Classic single cycle; waits on ack as long as it takes, a hang is left to the watchdog
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    // Taking edge plus one registered cycle to ack
    chk(n, 32'h2, "ack latency");
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  function automatic int dec(input logic [8:0] e);
    if (!e[8]) return int'(e[7:0]);
    return (e == 9'h1FE) ? -2 : -1;
  endfunction

  task automatic cfg(input logic [1:0] c, input logic [4:0] r, input logic [8:0] t);
    wb(1'b0, 8'h04, 4'hF, 32'h0);
    chk(q, {27'h0, m_cnt}, "status");
    wb(1'b1, 8'h00, 4'hF, {16'h0000, r, t, c});
    wb(1'b0, 8'h00, 4'hF, 32'h0);
    chk(q, {16'h0000, r, t, c}, "control");
    m_ctl = c;
    m_rld = r;
    m_thr = t;
  endtask

  task automatic contend(input int n, input logic s, input logic v, input logic [8:0] p,
                         input logic x);
    logic ev;
    @(posedge clk_i);
    sw_req <= s;
    want <= v;
    pri <= p;
    hi <= x;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      if (i == n - 1) begin
        sw_req <= 1'b0;
        want <= 1'b0;
      end
      @(negedge clk_i);
      ev = v;
      if (s && v) begin
        if (m_ctl == 2'h3) begin
          ev = x;
        end else if (m_cnt != 5'h00) begin
          ev = (m_ctl == 2'h1);
          m_cnt = m_cnt - 5'h01;
        end else begin
          ev = (m_ctl != 2'h1);
          m_cnt = (m_ctl == 2'h2 && dec(p) > dec(m_thr)) ? 5'h01 : m_rld;
        end
      end
      chk({30'h0, s & ~ev, ev}, {30'h0, sw_gnt_o, slv_gnt_o}, "grant");
    end
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h00, 4'hF, 32'h0);
    chk(q, 32'h00000800, "control reset");
    wb(1'b1, 8'h04, 4'hF, 32'hFFFFFFFF);
    wb(1'b0, 8'h08, 4'hF, 32'h0);
    chk(q, 32'h00000000, "unmapped");
    wb(1'b1, 8'h00, 4'h1, 32'hFFFFFFFF);
    wb(1'b0, 8'h00, 4'hF, 32'h0);
    chk(q, 32'h000008FF, "lane write");
    $display("Test registers done");
    // Reload one with mode zero or one is the round-robin setting; zero is never used
    cfg(2'h0, 5'h01, 9'h000);
    contend(6, 1'b1, 1'b1, 9'h000, 1'b0);
    contend(2, 1'b1, 1'b0, 9'h000, 1'b0);
    contend(2, 1'b0, 1'b1, 9'h000, 1'b0);
    cfg(2'h1, 5'h03, 9'h000);
    contend(10, 1'b1, 1'b1, 9'h000, 1'b0);
    $display("Test fixed demotion done");
    cfg(2'h2, 5'h04, 9'h010);
    contend(12, 1'b1, 1'b1, 9'h008, 1'b0);
    contend(6, 1'b1, 1'b1, 9'h010, 1'b0);
    contend(6, 1'b1, 1'b1, 9'h020, 1'b0);
    cfg(2'h2, 5'h04, 9'h1FF);
    contend(8, 1'b1, 1'b1, 9'h1FE, 1'b0);
    contend(6, 1'b1, 1'b1, 9'h07F, 1'b0);
    cfg(2'h2, 5'h04, 9'h1FE);
    contend(6, 1'b1, 1'b1, 9'h1FF, 1'b0);
    $display("Test threshold done");
    cfg(2'h3, 5'h07, 9'h000);
    contend(4, 1'b1, 1'b1, 9'h000, 1'b1);
    contend(4, 1'b1, 1'b1, 9'h000, 1'b0);
    cfg(2'h0, 5'h01, 9'h000);
    $display("Test external priority done");
    // Mid-run reset must restore every field, not only the power-up path
    wb(1'b1, 8'h00, 4'hF, 32'h0000FFFF);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h00, 4'hF, 32'h0);
    chk(q, 32'h00000800, "control after reset");
    wb(1'b0, 8'h04, 4'hF, 32'h0);
    chk(q, 32'h00000001, "counter after reset");
    $display("Test reset done");
    end_sim();
  end

  // All tests need well under 2000 cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    chk(32'h0, 32'h1, "watchdog expired");
    end_sim();
  end
endmodule

/* File: tb/spa_slv_model.sv */
// Behavioural model of the external master behind the slave port
`timescale 1ns/1ps
module spa_slv_model (
  input  wire logic rst_i,
  input  wire logic want_i,
  input  wire logic hi_pri_i,
  output logic      slv_req_o,
  output logic      ext_pri_o
);
  // Request stays up while data is pending; a granted beat is followed by the next
  assign slv_req_o = want_i & ~rst_i;
  // Integrating logic always drives the priority line, even outside mode three
  assign ext_pri_o = hi_pri_i;
endmodule
